// [hdl/rlsw_enable_dec.sv]
// Enable decoder: sequence slot, soft mode and pin OR for one power element
`timescale 1ns/1ps
module rlsw_enable_dec (
   rlsw_ctl_if.decoder ctl
);
   import rlsw_pkg::*;
   rlsw_seq_t seq;
   rlsw_mode_t mode;
   // Pin term is live only when sequence and mode both hand control to pins
   always_comb begin
      seq = rlsw_seq_t'(ctl.ena_reg[SEQ_MSB:SEQ_LSB]);
      mode = rlsw_mode_t'(ctl.ena_reg[MODE_MSB:MODE_LSB]);
      ctl.enable = 1'b0;
      unique case (seq)
         SEQ_ALWAYS: ctl.enable = ctl.allow_always & ctl.supply_ok;
         SEQ_BOOT0: ctl.enable = ctl.boot_0;
         SEQ_BOOT25: ctl.enable = ctl.boot_25;
         SEQ_BOOT50: ctl.enable = ctl.boot_50;
         SEQ_SOFT: begin
            unique case (mode)
               MODE_ON: ctl.enable = ctl.boot_done;
               MODE_PIN: ctl.enable = ctl.boot_done & |(ctl.pins & ctl.pin_sel);
               default: ctl.enable = 1'b0; // Off and reserved stay disabled
            endcase
         end
         default: ctl.enable = 1'b0; // Off and reserved codes
      endcase
   end
endmodule

// [hdl/rlsw_regs.sv]
// Top: clock regulator and switch one registers with enable and discharge control
`timescale 1ns/1ps
module rlsw_regs (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST,
   // Host register bus
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   output logic REG_HIT,
   // Control pins, sequencer levels and supply status
   input wire logic [7:0] MULTIPURPOSE_CONTROL_PIN,
   input wire logic BOOT_0,
   input wire logic BOOT_25,
   input wire logic BOOT_50,
   input wire logic BOOT_DONE,
   input wire logic SUPPLY_OK,
   input wire logic HARD_RESET,
   input wire logic OFF_ENTRY,
   input wire logic SWITCH_PROTECTION_TRIP,
   // Power element controls
   output logic CLOCK_REGULATOR_EN,
   output logic [11:0] CLOCK_REGULATOR_MV,
   output logic CLOCK_REGULATOR_PSV_DSC,
   output logic SWITCH_ONE_EN,
   output logic SWITCH_ONE_ACT_DSC,
   output logic SWITCH_ONE_PSV_DSC,
   output logic SWITCH_ONE_LOW_QUIESCENT
);
   import rlsw_pkg::*;
   logic [7:0] clk_ena_q;
   logic [7:0] clk_ena_d;
   logic [7:0] clk_cfg_q;
   logic [7:0] clk_cfg_d;
   logic [7:0] clk_sel_q;
   logic [7:0] clk_sel_d;
   logic [7:0] sw_ena_q;
   logic [7:0] sw_ena_d;
   logic [7:0] sw_cfg_q;
   logic [7:0] sw_cfg_d;
   logic [7:0] sw_sel_q;
   logic [7:0] sw_sel_d;
   logic [7:0] sync_q [SYNC_STAGES];
   logic [7:0] sync_d [SYNC_STAGES];
   logic clk_en_q;
   logic clk_en_d;
   logic sw_en_q;
   logic sw_en_d;
   logic clk_prev_q;
   logic clk_prev_d;
   logic sw_prev_q;
   logic sw_prev_d;
   logic clk_psv_q;
   logic clk_psv_d;
   logic sw_act_q;
   logic sw_act_d;
   logic sw_psv_q;
   logic sw_psv_d;
   logic [11:0] mv_q;
   logic [11:0] mv_d;
   logic clk_dec_en;
   logic sw_dec_en;
   rlsw_ctl_if clk_ctl ();
   rlsw_ctl_if sw_ctl ();

   // Register write masks keep reserved bits at zero
   function automatic logic [7:0] wr_field(input logic [7:0] cur, input logic [7:0] wd,
         input logic [7:0] mask, input logic hit);
      wr_field = hit ? (wd & mask) : cur;
   endfunction

   // Next register values; a write lands at the rising edge while REG_WR is high
   always_comb begin
      clk_ena_d = wr_field(clk_ena_q, REG_WDATA, MASK_ENABLE, REG_WR && REG_ADDR == ADDR_CLKREG_ENABLE);
      clk_cfg_d = wr_field(clk_cfg_q, REG_WDATA, MASK_CLKREG_CONFIG, REG_WR && REG_ADDR == ADDR_CLKREG_CONFIG);
      clk_sel_d = wr_field(clk_sel_q, REG_WDATA, 8'hff, REG_WR && REG_ADDR == ADDR_CLKREG_PINSEL);
      sw_ena_d = wr_field(sw_ena_q, REG_WDATA, MASK_ENABLE, REG_WR && REG_ADDR == ADDR_SW1_ENABLE);
      sw_cfg_d = wr_field(sw_cfg_q, REG_WDATA, MASK_SW1_CONFIG, REG_WR && REG_ADDR == ADDR_SW1_CONFIG);
      sw_sel_d = wr_field(sw_sel_q, REG_WDATA, 8'hff, REG_WR && REG_ADDR == ADDR_SW1_PINSEL);
   end

   // Register bank; reset values put both elements in their safe state
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         clk_ena_q <= RST_CLKREG_ENABLE;
         clk_cfg_q <= RST_CLKREG_CONFIG;
         clk_sel_q <= RST_PINSEL;
         sw_ena_q <= RST_SW1_ENABLE;
         sw_cfg_q <= RST_SW1_CONFIG;
         sw_sel_q <= RST_PINSEL;
      end else begin
         clk_ena_q <= clk_ena_d;
         clk_cfg_q <= clk_cfg_d;
         clk_sel_q <= clk_sel_d;
         sw_ena_q <= sw_ena_d;
         sw_cfg_q <= sw_cfg_d;
         sw_sel_q <= sw_sel_d;
      end
   end

   // Read mux is combinational so data is valid in the strobe cycle
   always_comb begin
      REG_HIT = 1'b1;
      unique case (REG_ADDR)
         ADDR_CLKREG_ENABLE: REG_RDATA = clk_ena_q;
         ADDR_CLKREG_CONFIG: REG_RDATA = clk_cfg_q;
         ADDR_CLKREG_PINSEL: REG_RDATA = clk_sel_q;
         ADDR_SW1_ENABLE: REG_RDATA = sw_ena_q;
         ADDR_SW1_CONFIG: REG_RDATA = sw_cfg_q;
         ADDR_SW1_PINSEL: REG_RDATA = sw_sel_q;
         default: begin
            REG_RDATA = 8'h00; // Unmapped reads as zero
            REG_HIT = 1'b0;
         end
      endcase
      if (!REG_RD) begin
         REG_RDATA = 8'h00;
         REG_HIT = 1'b0;
      end
   end

   // Two-stage pin synchroniser; only the last stage feeds the OR logic
   always_comb begin
      sync_d[0] = MULTIPURPOSE_CONTROL_PIN;
      for (int i = 1; i < SYNC_STAGES; i++) begin
         sync_d[i] = sync_q[i-1];
      end
   end

   // Synchroniser stages clear to the idle pin level
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         for (int i = 0; i < SYNC_STAGES; i++) begin
            sync_q[i] <= 8'h00;
         end
      end else begin
         sync_q <= sync_d;
      end
   end

   // Decoders share one structure; the switch has no always-on code
   assign clk_ctl.ena_reg = clk_ena_q;
   assign clk_ctl.pin_sel = clk_sel_q;
   assign clk_ctl.pins = sync_q[SYNC_STAGES-1];
   assign clk_ctl.boot_0 = BOOT_0;
   assign clk_ctl.boot_25 = BOOT_25;
   assign clk_ctl.boot_50 = BOOT_50;
   assign clk_ctl.boot_done = BOOT_DONE;
   assign clk_ctl.supply_ok = SUPPLY_OK;
   assign clk_ctl.allow_always = 1'b1;
   assign clk_dec_en = clk_ctl.enable;
   assign sw_ctl.ena_reg = sw_ena_q;
   assign sw_ctl.pin_sel = sw_sel_q;
   assign sw_ctl.pins = sync_q[SYNC_STAGES-1];
   assign sw_ctl.boot_0 = BOOT_0;
   assign sw_ctl.boot_25 = BOOT_25;
   assign sw_ctl.boot_50 = BOOT_50;
   assign sw_ctl.boot_done = BOOT_DONE;
   assign sw_ctl.supply_ok = SUPPLY_OK;
   assign sw_ctl.allow_always = 1'b0; // Code 001 reserved for the switch
   assign sw_dec_en = sw_ctl.enable;

   rlsw_enable_dec u_clk_dec (
      .ctl(clk_ctl)
   );

   rlsw_enable_dec u_sw_dec (
      .ctl(sw_ctl)
   );

   // Enables, discharge controls and voltage target
   always_comb begin
      clk_en_d = clk_dec_en;
      sw_en_d = sw_dec_en & (sw_cfg_q[LOWQ_BIT] | ~SWITCH_PROTECTION_TRIP);
      clk_prev_d = clk_en_q;
      sw_prev_d = sw_en_q;
      clk_psv_d = HARD_RESET | (clk_cfg_q[PSV_BIT] & clk_prev_q & ~clk_en_q);
      sw_act_d = HARD_RESET | (sw_cfg_q[ACT_BIT] & sw_prev_q & ~sw_en_q);
      sw_psv_d = HARD_RESET | OFF_ENTRY | (sw_cfg_q[PSV_BIT] & ~sw_en_q);
      mv_d = clk_cfg_q[BASE_BIT] ? BASE_HIGH_MV : BASE_LOW_MV;
      unique case (clk_cfg_q[INC_MSB:INC_LSB])
         2'h0: mv_d = mv_d;
         2'h1: mv_d = mv_d + INC_STEP_MV;
         default: mv_d = mv_d + INC_MAX_MV; // Codes 10 and 11 both add 50mV
      endcase
   end

   // Registered so enables and discharge commands change only on clock edges
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         clk_en_q <= 1'b0;
         sw_en_q <= 1'b0;
         clk_prev_q <= 1'b0;
         sw_prev_q <= 1'b0;
         clk_psv_q <= 1'b0;
         sw_act_q <= 1'b0;
         sw_psv_q <= 1'b0;
         mv_q <= BASE_LOW_MV;
      end else begin
         clk_en_q <= clk_en_d;
         sw_en_q <= sw_en_d;
         clk_prev_q <= clk_prev_d;
         sw_prev_q <= sw_prev_d;
         clk_psv_q <= clk_psv_d;
         sw_act_q <= sw_act_d;
         sw_psv_q <= sw_psv_d;
         mv_q <= mv_d;
      end
   end

   // Outputs come straight from flops so the analogue side sees no decode glitches
   assign CLOCK_REGULATOR_EN = clk_en_q;
   assign CLOCK_REGULATOR_MV = mv_q;
   assign CLOCK_REGULATOR_PSV_DSC = clk_psv_q;
   assign SWITCH_ONE_EN = sw_en_q;
   assign SWITCH_ONE_ACT_DSC = sw_act_q;
   assign SWITCH_ONE_PSV_DSC = sw_psv_q;
   assign SWITCH_ONE_LOW_QUIESCENT = sw_cfg_q[LOWQ_BIT];
endmodule

// [include/rlsw_ctl_if.sv]
// Interface: settings and pin state passed to the enable decoder
`timescale 1ns/1ps
interface rlsw_ctl_if;
   logic [7:0] ena_reg;
   logic [7:0] pin_sel;
   logic [7:0] pins;
   logic boot_0;
   logic boot_25;
   logic boot_50;
   logic boot_done;
   logic supply_ok;
   logic allow_always;
   logic enable;
   modport owner (output ena_reg, pin_sel, pins, boot_0, boot_25, boot_50, boot_done, supply_ok,
      allow_always, input enable);
   modport decoder (input ena_reg, pin_sel, pins, boot_0, boot_25, boot_50, boot_done, supply_ok,
      allow_always, output enable);
endinterface

// [include/rlsw_pkg.sv]
// Package: register map, field layout, reset values and enable decode codes
// Functional notes
// - Increment code 00 adds 0mV, 01 adds 25mV, 10 and 11 add 50mV.
// - Clock regulator base select: 0 gives 1.2V, 1 gives 1.8V, resets 0.
// - Clock regulator passive discharge: 0 hard-reset only, 1 also on enable fall.
// - Clock regulator pin selects act only with sequence 111 and mode 10.
// - Clock regulator pin enable is OR of selected pins; unselected pins ignored.
// - Switch one sequence: 000 off, 010/011/100 boot slots, 111 defers to mode.
// - Switch one mode acts only at sequence 111: 00 off, 01 on, 10 pins.
// - Switch one pin control uses the pin-select register at 0x6B.
// - Switch one active discharge: 0 hard-reset only, 1 also on enable fall.
// - Low quiescent 0 keeps protection trip active; 1 bypasses protection.
// - Switch one passive discharge: 0 on off/hard-reset entry, 1 also while enable low.
// - Clock regulator mode acts only at sequence 111: 00 off, 01 on, 10 pins.
// - Clock regulator sequence: 000 off, 001 always on, boot slots, 111 defers.
// - Switch one pin enable is OR of pins selected at 0x6B.
package rlsw_pkg;
   localparam logic [7:0] ADDR_CLKREG_ENABLE = 8'h66;
   localparam logic [7:0] ADDR_CLKREG_CONFIG = 8'h67;
   localparam logic [7:0] ADDR_CLKREG_PINSEL = 8'h68;
   localparam logic [7:0] ADDR_SW1_ENABLE = 8'h69;
   localparam logic [7:0] ADDR_SW1_CONFIG = 8'h6a;
   localparam logic [7:0] ADDR_SW1_PINSEL = 8'h6b;
   localparam logic [7:0] RST_CLKREG_ENABLE = 8'h00;
   localparam logic [7:0] RST_CLKREG_CONFIG = 8'h01;
   localparam logic [7:0] RST_PINSEL = 8'h00;
   localparam logic [7:0] RST_SW1_ENABLE = 8'h00;
   localparam logic [7:0] RST_SW1_CONFIG = 8'h01;
   localparam logic [7:0] MASK_ENABLE = 8'he3;
   localparam logic [7:0] MASK_CLKREG_CONFIG = 8'h0f;
   localparam logic [7:0] MASK_SW1_CONFIG = 8'h07;
   localparam int SEQ_MSB = 7;
   localparam int SEQ_LSB = 5;
   localparam int MODE_MSB = 1;
   localparam int MODE_LSB = 0;
   localparam int INC_MSB = 3;
   localparam int INC_LSB = 2;
   localparam int BASE_BIT = 1;
   localparam int PSV_BIT = 0;
   localparam int ACT_BIT = 2;
   localparam int LOWQ_BIT = 1;
   localparam int SYNC_STAGES = 2;
   // Output levels in millivolts
   localparam logic [11:0] BASE_LOW_MV = 12'h4b0;
   localparam logic [11:0] BASE_HIGH_MV = 12'h708;
   localparam logic [11:0] INC_STEP_MV = 12'h019;
   localparam logic [11:0] INC_MAX_MV = 12'h032;
   typedef enum logic [2:0] {
      SEQ_OFF = 3'h0, SEQ_ALWAYS = 3'h1, SEQ_BOOT0 = 3'h2, SEQ_BOOT25 = 3'h3,
      SEQ_BOOT50 = 3'h4, SEQ_RES5 = 3'h5, SEQ_RES6 = 3'h6, SEQ_SOFT = 3'h7
   } rlsw_seq_t;
   typedef enum logic [1:0] {
      MODE_OFF = 2'h0, MODE_ON = 2'h1, MODE_PIN = 2'h2, MODE_RES = 2'h3
   } rlsw_mode_t;
endpackage

// [tb/rlsw_host_model.sv]
// Host model: register writes and reads launched on falling clock edges
`timescale 1ns/1ps
module rlsw_host_model (
   input wire logic clk,
   output logic [7:0] addr,
   output logic [7:0] wdata,
   output logic wr,
   output logic rd,
   input wire logic [7:0] rdata,
   input wire logic hit
);
   initial {addr, wdata, wr, rd} = '0;
   // Strobe spans one rising edge; released lines are inverted so stale values never look valid
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      {addr, wdata, wr} = {a, d, 1'b1};
      @(negedge clk);
      {addr, wdata, wr} = {~a, ~d, 1'b0};
   endtask
   // Read data is combinational, so it is taken at the rising edge while the strobe stands
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic h);
      @(negedge clk);
      {addr, rd} = {a, 1'b1};
      @(posedge clk);
      {d, h} = {rdata, hit};
      @(negedge clk);
      {addr, rd} = {~a, 1'b0};
   endtask
endmodule

// [tb/rlsw_regs_assertions.sv]
// Checker: timing and value properties at the register block ports
`timescale 1ns/1ps
module rlsw_regs_chk (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_RDATA,
   input wire logic REG_HIT,
   input wire logic HARD_RESET,
   input wire logic SWITCH_PROTECTION_TRIP,
   input wire logic CLOCK_REGULATOR_EN,
   input wire logic [11:0] CLOCK_REGULATOR_MV,
   input wire logic CLOCK_REGULATOR_PSV_DSC,
   input wire logic SWITCH_ONE_EN,
   input wire logic SWITCH_ONE_ACT_DSC,
   input wire logic SWITCH_ONE_LOW_QUIESCENT
);
   import rlsw_pkg::*;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   logic wr_cfg;
   // Config write strobe; a second write right after would move the target again
   assign wr_cfg = REG_WR && REG_ADDR == ADDR_CLKREG_CONFIG;
   function automatic logic [11:0] mv_of(input logic [7:0] d);
      mv_of = (d[1] ? 12'h708 : 12'h4b0) + (d[3:2] == 2'h0 ? 12'h000 : d[3:2] == 2'h1 ? 12'h019 : 12'h032);
   endfunction
   property p_mv; wr_cfg ##1 !wr_cfg |=> CLOCK_REGULATOR_MV == mv_of($past(REG_WDATA, 2)); endproperty
   a_mv: assert property (p_mv) else $error("voltage target wrong");
   property p_act; SWITCH_ONE_ACT_DSC && !$past(HARD_RESET) |-> $past(SWITCH_ONE_EN, 2) && !$past(SWITCH_ONE_EN);
   endproperty
   a_act: assert property (p_act) else $error("active discharge without enable fall");
   property p_one; SWITCH_ONE_ACT_DSC && !HARD_RESET |=> !SWITCH_ONE_ACT_DSC; endproperty
   a_one: assert property (p_one) else $error("active discharge too long");
   property p_hr; HARD_RESET |=> SWITCH_ONE_ACT_DSC && CLOCK_REGULATOR_PSV_DSC; endproperty
   a_hr: assert property (p_hr) else $error("no discharge in hard reset");
   property p_cdsc; CLOCK_REGULATOR_PSV_DSC && !$past(HARD_RESET) |->
      $past(CLOCK_REGULATOR_EN, 2) && !$past(CLOCK_REGULATOR_EN); endproperty
   a_cdsc: assert property (p_cdsc) else $error("regulator discharge without enable fall");
   property p_trip; SWITCH_PROTECTION_TRIP && !SWITCH_ONE_LOW_QUIESCENT |=> !SWITCH_ONE_EN; endproperty
   a_trip: assert property (p_trip) else $error("protection did not open switch");
   property p_unmap; REG_RD && (REG_ADDR < ADDR_CLKREG_ENABLE || REG_ADDR > ADDR_SW1_PINSEL) |->
      REG_RDATA == 8'h00 && !REG_HIT; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read answered");
   property p_hit; REG_RD && REG_ADDR >= ADDR_CLKREG_ENABLE && REG_ADDR <= ADDR_SW1_PINSEL |-> REG_HIT; endproperty
   a_hit: assert property (p_hit) else $error("mapped read not flagged");
endmodule
bind rlsw_regs rlsw_regs_chk rlsw_regs_chk_inst (
   .CORE_CLK(CORE_CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
   .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_HIT(REG_HIT), .HARD_RESET(HARD_RESET),
   .SWITCH_PROTECTION_TRIP(SWITCH_PROTECTION_TRIP), .CLOCK_REGULATOR_EN(CLOCK_REGULATOR_EN),
   .CLOCK_REGULATOR_MV(CLOCK_REGULATOR_MV), .CLOCK_REGULATOR_PSV_DSC(CLOCK_REGULATOR_PSV_DSC),
   .SWITCH_ONE_EN(SWITCH_ONE_EN), .SWITCH_ONE_ACT_DSC(SWITCH_ONE_ACT_DSC),
   .SWITCH_ONE_LOW_QUIESCENT(SWITCH_ONE_LOW_QUIESCENT)
);

// [tb/rlsw_regs_tb.sv]
// Testbench: register map, voltage target, enable decode, pin control and discharge
`timescale 1ns/1ps
module rlsw_regs_tb;
   import rlsw_pkg::*;
   localparam logic [7:0] CSEL = 8'h30;
   localparam logic [7:0] SSEL = 8'h0c;
   logic CORE_CLK = 1'b0;
   logic RST = 1'b1;
   logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, MULTIPURPOSE_CONTROL_PIN, rdat;
   logic REG_WR, REG_RD, REG_HIT, BOOT_0, BOOT_25, BOOT_50, BOOT_DONE, SUPPLY_OK, HARD_RESET, OFF_ENTRY, rhit;
   logic SWITCH_PROTECTION_TRIP, CLOCK_REGULATOR_EN, CLOCK_REGULATOR_PSV_DSC, SWITCH_ONE_EN, SWITCH_ONE_ACT_DSC;
   logic SWITCH_ONE_PSV_DSC, SWITCH_ONE_LOW_QUIESCENT;
   logic [11:0] CLOCK_REGULATOR_MV;
   int n_fail = 0;
   int checks = 0;
   always #10 CORE_CLK = ~CORE_CLK;
   rlsw_regs rlsw_regs_inst (.*);
   rlsw_host_model rlsw_host_model_inst (.clk(CORE_CLK), .addr(REG_ADDR), .wdata(REG_WDATA), .wr(REG_WR),
      .rd(REG_RD), .rdata(REG_RDATA), .hit(REG_HIT));
   task automatic results;
      if (n_fail == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge CORE_CLK);
   endtask
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      rlsw_host_model_inst.wr_reg(a, d);
   endtask
   // Expected enable; alw admits the always-on code, which the switch treats as reserved
   function automatic logic en_exp(input logic [7:0] r, input logic alw, input logic [7:0] sel);
      case (r[7:5])
         3'h1: en_exp = alw & SUPPLY_OK;
         3'h2: en_exp = BOOT_0;
         3'h3: en_exp = BOOT_25;
         3'h4: en_exp = BOOT_50;
         3'h7: en_exp = BOOT_DONE & (r[1:0] == 2'h1 | r[1:0] == 2'h2 & |(sel & MULTIPURPOSE_CONTROL_PIN));
         default: en_exp = 1'b0;
      endcase
   endfunction
   // Reset values, then all-ones writes show the kept bits; both range ends are unmapped
   task automatic t_regs;
      logic [7:0] a;
      logic [7:0] m [8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
      logic [7:0] k [8] = '{8'h00, 8'he3, 8'h0f, 8'hff, 8'he3, 8'h07, 8'hff, 8'h00};
      chk("mv", 12'h4b0, CLOCK_REGULATOR_MV);
      for (int i = 0; i < 8; i++) begin
         a = 8'h65 + 8'(i);
         rlsw_host_model_inst.rd_reg(a, rdat, rhit);
         chk("reset", 12'(m[i]), 12'(rdat));
         chk("hit", 12'(i > 0 && i < 7), 12'(rhit));
         w(a, 8'hff);
         rlsw_host_model_inst.rd_reg(a, rdat, rhit);
         chk("rw", 12'(k[i]), 12'(rdat));
      end
   endtask
   // Every base and increment code at the voltage target
   task automatic t_mv;
      logic [2:0] c;
      logic [11:0] e;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         w(ADDR_CLKREG_CONFIG, {4'h0, c, 1'b0});
         tick(3);
         e = c[2:1] == 2'h0 ? 12'h000 : c[2:1] == 2'h1 ? 12'h019 : 12'h032;
         chk("mv", e + (c[0] ? 12'h708 : 12'h4b0), CLOCK_REGULATOR_MV);
      end
   endtask
   // All sequence and mode codes for both elements under one boot and pin state
   task automatic t_enable(input logic [4:0] boot, input logic [7:0] p);
      logic [7:0] r;
      {SUPPLY_OK, BOOT_DONE, BOOT_50, BOOT_25, BOOT_0} = boot;
      MULTIPURPOSE_CONTROL_PIN = p;
      for (int i = 0; i < 32; i++) begin
         r = {3'(i >> 2), 3'h0, 2'(i)};
         w(ADDR_CLKREG_ENABLE, r);
         w(ADDR_SW1_ENABLE, r);
         tick(3);
         chk("clk en", 12'(en_exp(r, 1'b1, CSEL)), 12'(CLOCK_REGULATOR_EN));
         chk("sw en", 12'(en_exp(r, 1'b0, SSEL)), 12'(SWITCH_ONE_EN));
      end
   endtask
   // Walking pin; the enable must not follow within one edge, the synchroniser needs two
   task automatic t_pins;
      logic e;
      w(ADDR_CLKREG_ENABLE, 8'he2);
      w(ADDR_SW1_ENABLE, 8'he2);
      tick(3);
      for (int i = 0; i < 9; i++) begin
         e = en_exp(8'he2, 1'b1, CSEL);
         MULTIPURPOSE_CONTROL_PIN = 8'(1 << i);
         tick(1);
         chk("pin sync", 12'(e), 12'(CLOCK_REGULATOR_EN));
         tick(3);
         chk("clk pin", 12'(en_exp(8'he2, 1'b1, CSEL)), 12'(CLOCK_REGULATOR_EN));
         chk("sw pin", 12'(en_exp(8'he2, 1'b0, SSEL)), 12'(SWITCH_ONE_EN));
      end
   endtask
   // Both elements turned on then off; count discharge pulses in a short window each
   task automatic t_dsc(input logic [7:0] cfg);
      int n;
      int m;
      n = 0;
      m = 0;
      w(ADDR_SW1_CONFIG, cfg);
      w(ADDR_CLKREG_CONFIG, {7'h00, cfg[0]});
      w(ADDR_SW1_ENABLE, 8'he1);
      w(ADDR_CLKREG_ENABLE, 8'he1);
      tick(3);
      w(ADDR_SW1_ENABLE, 8'h00);
      repeat (5) begin
         tick(1);
         n += SWITCH_ONE_ACT_DSC;
      end
      w(ADDR_CLKREG_ENABLE, 8'h00);
      repeat (5) begin
         tick(1);
         m += CLOCK_REGULATOR_PSV_DSC;
      end
      chk("act pulses", 12'(cfg[2]), 12'(n));
      chk("clk psv pulses", 12'(cfg[0]), 12'(m));
      chk("sw psv", 12'(cfg[0]), 12'(SWITCH_ONE_PSV_DSC));
   endtask
   task automatic t_hard;
      HARD_RESET = 1'b1;
      tick(2);
      chk("hr act", 12'h001, 12'(SWITCH_ONE_ACT_DSC));
      chk("hr psv", 12'h001, 12'(CLOCK_REGULATOR_PSV_DSC));
      {HARD_RESET, OFF_ENTRY} = 2'h1;
      tick(2);
      chk("off psv", 12'h001, 12'(SWITCH_ONE_PSV_DSC));
      OFF_ENTRY = 1'b0;
   endtask
   // Protection opens the switch unless the low quiescent bit bypasses it
   task automatic t_trip;
      w(ADDR_SW1_ENABLE, 8'he1);
      SWITCH_PROTECTION_TRIP = 1'b1;
      tick(3);
      chk("trip en", 12'h000, 12'(SWITCH_ONE_EN));
      w(ADDR_SW1_CONFIG, 8'h02);
      tick(3);
      chk("lowq en", 12'h001, 12'(SWITCH_ONE_EN));
      chk("lowq", 12'h001, 12'(SWITCH_ONE_LOW_QUIESCENT));
   endtask
   initial begin
      {MULTIPURPOSE_CONTROL_PIN, BOOT_0, BOOT_25, BOOT_50, BOOT_DONE, SUPPLY_OK} = '0;
      {HARD_RESET, OFF_ENTRY, SWITCH_PROTECTION_TRIP} = '0;
      repeat (20) @(negedge CORE_CLK);
      RST = 1'b0;
      t_regs();
      t_mv();
      w(ADDR_CLKREG_CONFIG, 8'h01);
      w(ADDR_CLKREG_PINSEL, CSEL);
      w(ADDR_SW1_PINSEL, SSEL);
      w(ADDR_SW1_CONFIG, 8'h05);
      t_enable(5'h15, 8'h10);
      t_enable(5'h0a, 8'h04);
      t_pins();
      t_dsc(8'h05);
      t_dsc(8'h00);
      t_hard();
      t_trip();
      results();
   end
endmodule
